// >>> core/uart_frame_pkg.sv
/*
  Shared constants and types for the serial frame and data block: register
  offsets, field positions, reset values, bit timing and packed carriers.
  Assumes a 50 MHz core clock and a byte-addressed register port.
*/
package uart_frame_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_FRAME_FORMAT_CONTROL = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h20;
  localparam logic [7:0] OFS_IMASK = 8'h24;
  // frame-control field layout
  localparam int FC_WIDTH = 7;
  localparam logic [FC_WIDTH-1:0] FRAME_FORMAT_CONTROL_RESET = 7'h00;
  // receive word layout
  localparam int RW_WIDTH = 12;
  localparam int RW_FRM = 8;
  localparam int RW_PAR = 9;
  localparam int RW_OVR = 10;
  localparam int RW_BRK = 11;
  // interrupt status layout
  localparam int IS_WIDTH = 6;
  localparam int IS_RX = 0;
  localparam int IS_TXDONE = 1;
  localparam int IS_OVR = 2;
  localparam int IS_BRK = 3;
  localparam int IS_PAR = 4;
  localparam int IS_FRM = 5;
  localparam logic [IS_WIDTH-1:0] IS_RESET = 6'h00;
  // bit timing
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_BPS = 115200;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [1:0] word_length_select;
    logic fifo_on;
    logic two_stop_select;
    logic even_parity_select;
    logic parity_on;
    logic send_break;
  } frame_format_control_t;

  typedef struct packed {
    logic break_flag;
    logic overrun_flag;
    logic parity_fault_flag;
    logic framing_fault_flag;
    logic [7:0] data;
  } rx_word_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT} rx_state_t;
endpackage : uart_frame_pkg

// >>> core/uart_frame_data_control.sv
/*
  Serial frame and data path: character FIFOs, transmitter, receiver,
  register port and interrupt logic.
  Assumes all inputs are synchronous to I_CORE_CLK and that the line
  idles high; bit time is BIT_CYCLES core clocks, BIT_CYC by default.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

// character fifo; holds one entry when i_fen is low
module uart_char_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // async reset
  input wire logic i_ce, // clock enable
  input wire logic i_fen, // buffered mode
  input wire logic i_push, // write entry
  input wire logic [W-1:0] i_din, // entry in
  input wire logic i_pop, // drop head
  output logic o_full, // no room
  output logic o_empty, // nothing held
  output logic [W-1:0] o_dout // head entry
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cap;
  logic do_push, do_pop;

  // capacity follows the buffering mode
  assign cap = i_fen ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign o_full = cnt_q >= cap;
  assign o_empty = cnt_q == '0;
  assign o_dout = mem[rp_q];
  assign do_push = i_ce & i_push & ~o_full;
  assign do_pop = i_ce & i_pop & ~o_empty;

  // storage array
  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wp_q] <= i_din;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : uart_char_fifo

// Notes on behaviour
// - line low through a whole frame sets break flag, data reads zero
// - parity on and parity bit wrong for even/odd sense sets parity fault
// - missing stop bit sets the framing fault flag
// - data word reads zero above bit 11; flag bits ignore writes
// - received character stays readable after a read until replaced
// - writing data word low byte queues a character for sending
// - word length 11/10/01/00 gives 8/7/6/5 bits both ways
// - fifo enable selects buffered mode, else single holding entry
// - two-stop bit sends two stop bits, else one
// - receiver checks only the first stop bit
// - parity sense bit: set even, clear odd; idle without parity
// - parity enable adds parity on send and checks it on receive
// - break bit ends current character then holds line low
// - frame control reads zero above bit 6
// - error flags change only with the next received character
module uart_frame_data_control
  import uart_frame_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic I_CORE_CLK, // core clock
  input wire logic I_RST, // async reset, high
  input wire logic I_CE, // clock enable
  input wire logic [7:0] I_ADDR, // register byte address
  input wire logic [31:0] I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  output logic [31:0] O_RDATA, // read data, cycle after strobe
  output logic O_IRQ, // interrupt level
  input wire logic I_SERIAL_RX_IN, // serial line in
  output logic O_SERIAL_TX_OUT // serial_tx_out line
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BITM1 = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALFM1 = CW'(BIT_CYCLES / 2 - 1);

  if (BIT_CYCLES < 4 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("unsupported bit time or fifo depth");
  end

  frame_format_control_t fc_q;
  logic [IS_WIDTH-1:0] ist_q, ist_d, msk_q, ev;
  logic [RW_WIDTH-1:0] last_q;
  logic [31:0] rdata_d;
  logic ovr_pend_q;
  logic hit_data, hit_frame_format_control, hit_ist, hit_msk;
  logic wr_data, rd_data, wr_frame_format_control, wr_ist, wr_msk;
  logic [2:0] last_idx;
  logic [7:0] dmask;
  logic tx_full, tx_empty, tx_pop, tx_fin, tx_tick, tx_pbit, tx_d, tx_q;
  logic [7:0] tx_dout, tx_sh_q, tx_sh_d;
  logic [CW-1:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [2:0] tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
  logic tx_stp_q, tx_stp_d;
  tx_state_t tx_st_q, tx_st_d;
  rx_state_t rx_st_q, rx_st_d;
  logic rx_full, rx_empty, rx_push, rx_pop, rx_done, rx_tick;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_pb_q, rx_pb_d, rx_zero_q, rx_zero_d;
  rx_word_t rx_word, rx_head;

  // register decode
  assign hit_data = I_ADDR == OFS_DATA;
  assign hit_frame_format_control = I_ADDR == OFS_FRAME_FORMAT_CONTROL;
  assign hit_ist = I_ADDR == OFS_ISTAT;
  assign hit_msk = I_ADDR == OFS_IMASK;
  assign wr_data = I_WR & hit_data;
  assign rd_data = I_RD & hit_data;
  assign wr_frame_format_control = I_WR & hit_frame_format_control;
  assign wr_ist = I_WR & hit_ist;
  assign wr_msk = I_WR & hit_msk;

  // character size and data mask from word length
  assign last_idx = {1'b1, fc_q.word_length_select};
  assign dmask = 8'hFF >> (2'd3 - fc_q.word_length_select);

  // transmit queue; host low byte becomes next character
  uart_char_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_fen(fc_q.fifo_on),
    .i_push(wr_data),
    .i_din(I_WDATA[7:0]),
    .i_pop(tx_pop),
    .o_full(tx_full),
    .o_empty(tx_empty),
    .o_dout(tx_dout)
  );

  // receive queue of characters with their flags
  uart_char_fifo #(.W(RW_WIDTH), .DEPTH(DEPTH)) u_rxq (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_fen(fc_q.fifo_on),
    .i_push(rx_push),
    .i_din(rx_word),
    .i_pop(rx_pop),
    .o_full(rx_full),
    .o_empty(rx_empty),
    .o_dout(rx_head)
  );

  // transmitter bit timing and parity
  assign tx_tick = tx_cnt_q == '0;
  assign tx_pbit = ^(tx_sh_q & dmask) ^ ~fc_q.even_parity_select;

  // transmitter sequencing
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_tick ? BITM1 : tx_cnt_q - 1'b1;
    tx_idx_d = tx_idx_q;
    tx_sh_d = tx_sh_q;
    tx_stp_d = tx_stp_q;
    tx_pop = 1'b0;
    tx_fin = 1'b0;
    unique case (tx_st_q)
      TX_IDLE: begin
        tx_cnt_d = BITM1;
        if (fc_q.send_break) begin
          tx_st_d = TX_BREAK;
        end else if (!tx_empty) begin
          tx_pop = 1'b1;
          tx_sh_d = tx_dout;
          tx_st_d = TX_START;
        end
      end
      TX_START: begin
        tx_idx_d = 3'd0;
        if (tx_tick) tx_st_d = TX_DATA;
      end
      TX_DATA: begin
        if (tx_tick) begin
          tx_idx_d = tx_idx_q + 1'b1;
          tx_stp_d = fc_q.two_stop_select;
          if (tx_idx_q == last_idx) begin
            tx_st_d = fc_q.parity_on ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        tx_stp_d = fc_q.two_stop_select;
        if (tx_tick) tx_st_d = TX_STOP;
      end
      TX_STOP: begin
        if (tx_tick) begin
          tx_stp_d = 1'b0;
          if (!tx_stp_q) begin
            tx_st_d = TX_IDLE;
            tx_fin = 1'b1;
          end
        end
      end
      TX_BREAK: begin
        tx_cnt_d = BITM1;
        if (!fc_q.send_break) tx_st_d = TX_IDLE;
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  // transmit line level: low start, data lsb first, parity, high stop
  assign tx_d = (tx_st_q == TX_START || tx_st_q == TX_BREAK) ? 1'b0 :
                (tx_st_q == TX_DATA) ? tx_sh_q[tx_idx_q] :
                (tx_st_q == TX_PAR) ? tx_pbit : 1'b1;
  assign O_SERIAL_TX_OUT = tx_q;

  // transmitter registers
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
      tx_sh_q <= '0;
      tx_stp_q <= 1'b0;
      tx_q <= 1'b1;
    end else if (I_CE) begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_idx_q <= tx_idx_d;
      tx_sh_q <= tx_sh_d;
      tx_stp_q <= tx_stp_d;
      tx_q <= tx_d;
    end
  end

  // receiver sampling at mid bit
  assign rx_tick = rx_cnt_q == '0;

  // receiver sequencing
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_tick ? BITM1 : rx_cnt_q - 1'b1;
    rx_idx_d = rx_idx_q;
    rx_sh_d = rx_sh_q;
    rx_pb_d = rx_pb_q;
    rx_zero_d = rx_zero_q;
    rx_done = 1'b0;
    unique case (rx_st_q)
      RX_IDLE: begin
        rx_cnt_d = HALFM1;
        rx_sh_d = 8'h00;
        rx_pb_d = 1'b0;
        rx_zero_d = 1'b1;
        rx_idx_d = 3'd0;
        if (!I_SERIAL_RX_IN) rx_st_d = RX_START;
      end
      RX_START: begin
        if (rx_tick) rx_st_d = I_SERIAL_RX_IN ? RX_IDLE : RX_DATA;
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_sh_d[rx_idx_q] = I_SERIAL_RX_IN;
          rx_zero_d = rx_zero_q & ~I_SERIAL_RX_IN;
          rx_idx_d = rx_idx_q + 1'b1;
          if (rx_idx_q == last_idx) begin
            rx_st_d = fc_q.parity_on ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          rx_pb_d = I_SERIAL_RX_IN;
          rx_zero_d = rx_zero_q & ~I_SERIAL_RX_IN;
          rx_st_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_done = 1'b1;
          rx_st_d = I_SERIAL_RX_IN ? RX_IDLE : RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (I_SERIAL_RX_IN) rx_st_d = RX_IDLE;
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  // assemble the received word at the first stop sample
  assign rx_word.break_flag = ~I_SERIAL_RX_IN & rx_zero_q;
  assign rx_word.overrun_flag = ovr_pend_q;
  assign rx_word.parity_fault_flag = fc_q.parity_on &
                                     (^(rx_sh_q & dmask) ^ rx_pb_q ^ ~fc_q.even_parity_select);
  assign rx_word.framing_fault_flag = ~I_SERIAL_RX_IN;
  assign rx_word.data = rx_word.break_flag ? 8'h00 : (rx_sh_q & dmask);
  assign rx_push = rx_done;
  assign rx_pop = rd_data;

  // receiver registers
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q <= '0;
      rx_pb_q <= 1'b0;
      rx_zero_q <= 1'b1;
    end else if (I_CE) begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_idx_q <= rx_idx_d;
      rx_sh_q <= rx_sh_d;
      rx_pb_q <= rx_pb_d;
      rx_zero_q <= rx_zero_d;
    end
  end

  // overrun: lost character marks the next stored one
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ovr_pend_q <= 1'b0;
    end else if (I_CE && rx_done) begin
      ovr_pend_q <= rx_full;
    end
  end

  // interrupt events and sticky status; a set beats a clear
  assign ev[IS_RX] = rx_done & ~rx_full;
  assign ev[IS_TXDONE] = tx_fin & tx_empty;
  assign ev[IS_OVR] = rx_done & rx_full;
  assign ev[IS_BRK] = rx_done & rx_word.break_flag;
  assign ev[IS_PAR] = rx_done & rx_word.parity_fault_flag;
  assign ev[IS_FRM] = rx_done & rx_word.framing_fault_flag;
  assign ist_d = (ist_q & ~(wr_ist ? I_WDATA[IS_WIDTH-1:0] : '0)) | ev;
  assign O_IRQ = |(ist_q & msk_q);

  // read mux; upper bits read zero
  assign rdata_d = hit_data ? {20'h00000, rx_empty ? last_q : rx_head} :
                   hit_frame_format_control ? {25'h0000000, fc_q} :
                   hit_ist ? {26'h0000000, ist_q} :
                   hit_msk ? {26'h0000000, msk_q} : 32'h00000000;

  // host-visible registers
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      fc_q <= FRAME_FORMAT_CONTROL_RESET;
      ist_q <= IS_RESET;
      msk_q <= IS_RESET;
      last_q <= '0;
      O_RDATA <= '0;
    end else if (I_CE) begin
      ist_q <= ist_d;
      if (wr_frame_format_control) fc_q <= I_WDATA[FC_WIDTH-1:0];
      if (wr_msk) msk_q <= I_WDATA[IS_WIDTH-1:0];
      if (rd_data && !rx_empty) last_q <= rx_head;
      O_RDATA <= I_RD ? rdata_d : 32'h00000000;
    end
  end

  // checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  AST_DATA_HI_ZERO: assert property (
    I_CE && rd_data |=> O_RDATA[31:12] == 20'h00000)
    else $error("data word upper bits not zero");
  AST_FRAME_FORMAT_CONTROL_HI_ZERO: assert property (
    I_CE && I_RD && hit_frame_format_control |=> O_RDATA[31:7] == 25'h0000000)
    else $error("frame control upper bits not zero");
  AST_BREAK_DATA: assert property (
    rx_done && rx_word.break_flag |-> rx_word.data == 8'h00 && rx_word.framing_fault_flag)
    else $error("break word carries data");
  AST_NO_PAR_CHECK: assert property (
    rx_done && !fc_q.parity_on |-> !rx_word.parity_fault_flag)
    else $error("parity fault without parity");
  AST_STOP_OK: assert property (
    rx_done && I_SERIAL_RX_IN |-> !rx_word.framing_fault_flag && rx_st_d == RX_IDLE)
    else $error("good stop flagged");
  AST_START_LOW: assert property (
    I_CE && tx_st_q == TX_START ##1 I_CE |-> !O_SERIAL_TX_OUT)
    else $error("start bit not low");
  AST_BREAK_HOLD: assert property (
    I_CE && tx_st_q == TX_BREAK ##1 I_CE && tx_st_q == TX_BREAK |-> !O_SERIAL_TX_OUT)
    else $error("line not low in break");
  AST_BREAK_RELEASE: assert property (
    I_CE && tx_st_q == TX_BREAK && !fc_q.send_break |=> tx_st_q == TX_IDLE)
    else $error("break not released");
  AST_KEEP_LAST: assert property (
    I_CE && rd_data && rx_empty |=> O_RDATA[11:0] == $past(last_q))
    else $error("held character lost");
  AST_OVR_FLAG: assert property (
    I_CE && rx_done && rx_full |=> ovr_pend_q && ist_q[IS_OVR])
    else $error("overrun not flagged");
  AST_SET_WINS: assert property (
    I_CE && ev[IS_RX] && wr_ist && I_WDATA[IS_RX] |=> ist_q[IS_RX])
    else $error("event lost under clear");

  COV_BREAK_RX: cover property (rx_done && rx_word.break_flag);
  COV_PAR_ERR: cover property (rx_done && rx_word.parity_fault_flag);
  COV_OVERRUN: cover property (rx_done && rx_full);
  COV_TX_BREAK: cover property (tx_st_q == TX_BREAK ##1 tx_st_q == TX_IDLE);
endmodule : uart_frame_data_control

// >>> sim/uart_line_partner.sv
/*
  remote serial station: sends frames on the device receive line and
  samples frames from the device transmit line.
  assumes an idle-high line and a bit time of BIT core clocks.
*/
`timescale 1ns/1ps
module uart_line_partner #(
  parameter int BIT = 8
) (
  input wire logic i_clk, // core clock
  input wire logic i_line, // device transmit line
  output logic o_line // device receive line
);
  // line idles high between frames
  initial o_line = 1'b1;

  // start bit, then bits lsb first, then release; gap must be at least one
  task automatic send_frame(input logic [11:0] bits, input int n, input int gap);
    repeat (gap) @(posedge i_clk);
    o_line <= 1'b0;
    repeat (BIT) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (BIT) @(posedge i_clk);
    end
    o_line <= 1'b1;
  endtask : send_frame

  // find the start edge, then sample each bit in its middle
  task automatic catch_frame(input int n, output logic [11:0] bits, output bit ok);
    int t;
    bits = 12'h000;
    t = 0;
    while (i_line !== 1'b0 && t < 400) begin
      @(posedge i_clk);
      t++;
    end
    repeat (BIT / 2) @(posedge i_clk);
    ok = (t < 400) && (i_line === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge i_clk);
      bits[i] = i_line;
    end
  endtask : catch_frame
endmodule : uart_line_partner

// >>> sim/uart_frame_data_control_tb.sv
/*
  self-checking bench for the serial frame and data block: a row table of
  framing modes, then reset, reserved, fifo, overrun, interrupt and break.
  assumes the partner model drives the receive line and samples tx.
*/
`timescale 1ns/1ps
module uart_frame_data_control_tb;
  import uart_frame_pkg::*;
  localparam int BITC = 8;
  typedef struct packed {
    logic [6:0] fc; // frame control
    logic [7:0] ch; // character both ways
    logic [1:0] err; // bit0 bad parity, bit1 first stop low
    logic [11:0] exp; // expected receive word
  } row_t;
  row_t rows [6] = '{
    '{7'h60, 8'hA5, 2'h0, 12'h0A5}, '{7'h46, 8'h3C, 2'h0, 12'h03C},
    '{7'h22, 8'h5B, 2'h1, 12'h21B}, '{7'h08, 8'h1F, 2'h2, 12'h11F},
    '{7'h64, 8'h81, 2'h0, 12'h081}, '{7'h7A, 8'hC3, 2'h2, 12'h1C3}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic rx_line;
  logic tx_line;
  logic ce = 1'b1;
  int errors = 0;
  int checks = 0;
  int n;

  // 50 MHz core clock
  always #10 clk = ~clk;

  uart_frame_data_control #(.BIT_CYCLES(BITC), .DEPTH(4)) i_uart_frame_data_control (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_IRQ(irq),
    .I_SERIAL_RX_IN(rx_line), .O_SERIAL_TX_OUT(tx_line));
  uart_line_partner #(.BIT(BITC)) i_uart_line_partner (
    .i_clk(clk), .i_line(tx_line), .o_line(rx_line));

  // frame bits after the start bit, with the count in the top nibble
  function automatic logic [15:0] frame(input logic [6:0] fc, input logic [7:0] ch);
    int nb;
    int k;
    logic [11:0] b;
    nb = 5 + fc[6:5];
    b = 12'hFFF;
    for (int i = 0; i < nb; i++) b[i] = ch[i];
    k = nb + 1 + fc[3];
    if (fc[1]) begin
      b[nb] = ^(ch & 8'((1 << nb) - 1)) ^ ~fc[2];
      k++;
    end
    return {4'(k), b};
  endfunction : frame

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(what, e, rdata);
  endtask : rd_chk

  task automatic tx_chk(input logic [6:0] fc, input logic [7:0] ch);
    logic [15:0] fr;
    logic [11:0] b;
    bit ok;
    fr = frame(fc, ch);
    i_uart_line_partner.catch_frame(int'(fr[15:12]), b, ok);
    chk("tx start", 32'h1, {31'h0, ok});
    chk("tx frame", {20'h0, fr[11:0] & 12'((1 << fr[15:12]) - 1)}, {20'h0, b});
  endtask : tx_chk

  task automatic rx_send(input logic [6:0] fc, input logic [7:0] ch, input logic [1:0] err);
    logic [15:0] fr;
    int s;
    fr = frame(fc, ch);
    s = int'(fr[15:12]) - 1 - fc[3];
    if (err[0]) fr[s-1] = ~fr[s-1];
    if (err[1]) fr[s] = 1'b0;
    i_uart_line_partner.send_frame(fr[11:0], int'(fr[15:12]), 1);
  endtask : rx_send

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      wr(OFS_FRAME_FORMAT_CONTROL, {25'h0, rows[k].fc});
      rd_chk(OFS_FRAME_FORMAT_CONTROL, {25'h0, rows[k].fc}, "frame_format_control");
      wr(OFS_DATA, {24'h0, rows[k].ch});
      tx_chk(rows[k].fc, rows[k].ch);
      rx_send(rows[k].fc, rows[k].ch, rows[k].err);
      rd_chk(OFS_DATA, {20'h0, rows[k].exp}, "rx word");
    end
    $display("test rows done");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_FRAME_FORMAT_CONTROL, 32'h0, "frame_format_control reset");
    rd_chk(OFS_DATA, 32'h0, "data reset");
    chk("irq reset", 32'h0, {31'h0, irq});
    chk("tx idle", 32'h1, {31'h0, tx_line});
    wr(OFS_FRAME_FORMAT_CONTROL, 32'hFFFF_FFFF);
    rd_chk(OFS_FRAME_FORMAT_CONTROL, 32'h0000_007F, "frame_format_control reserved");
    wr(8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0, "unmapped");
    // a write while the clock enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_FRAME_FORMAT_CONTROL, 32'h60);
    ce <= 1'b1;
    rd_chk(OFS_FRAME_FORMAT_CONTROL, 32'h0000_007F, "frozen");
    $display("test reset done");
    // buffered mode, two stops sent but one received
    wr(OFS_FRAME_FORMAT_CONTROL, 32'h78);
    rx_send(7'h70, 8'h12, 2'h0);
    rx_send(7'h70, 8'h34, 2'h0);
    rd_chk(OFS_DATA, 32'h012, "fifo first");
    rd_chk(OFS_DATA, 32'h034, "fifo second");
    wr(OFS_DATA, 32'h5A);
    wr(OFS_DATA, 32'hC6);
    tx_chk(7'h78, 8'h5A);
    tx_chk(7'h78, 8'hC6);
    $display("test fifo done");
    // single holding entry: second character is lost
    wr(OFS_FRAME_FORMAT_CONTROL, 32'h60);
    wr(OFS_ISTAT, 32'h3F);
    rx_send(7'h60, 8'h11, 2'h0);
    rx_send(7'h60, 8'h22, 2'h0);
    rd_chk(OFS_DATA, 32'h011, "kept");
    rx_send(7'h60, 8'h33, 2'h0);
    rd_chk(OFS_DATA, 32'h433, "overrun");
    rd_chk(OFS_DATA, 32'h433, "reread");
    rd_chk(OFS_ISTAT, 32'h05, "status");
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(OFS_IMASK, 32'h4);
    #1 chk("irq on", 32'h1, {31'h0, irq});
    wr(OFS_ISTAT, 32'h4);
    #1 chk("irq off", 32'h0, {31'h0, irq});
    wr(OFS_DATA, 32'hFFFF_FF00);
    tx_chk(7'h60, 8'h00);
    rd_chk(OFS_DATA, 32'h433, "flags kept");
    $display("test overrun done");
    // break both ways
    i_uart_line_partner.send_frame(12'h000, 12, 1);
    rd_chk(OFS_DATA, 32'h900, "break word");
    wr(OFS_DATA, 32'h96);
    wr(OFS_FRAME_FORMAT_CONTROL, 32'h61);
    tx_chk(7'h60, 8'h96);
    n = 0;
    repeat (BITC) @(posedge clk);
    // break kept longer than a frame
    repeat (12 * BITC) begin
      @(posedge clk);
      if (tx_line !== 1'b0) n++;
    end
    chk("break held", 32'h0, 32'(n));
    wr(OFS_FRAME_FORMAT_CONTROL, 32'h60);
    repeat (3) @(posedge clk);
    #1 chk("break released", 32'h1, {31'h0, tx_line});
    wr(OFS_DATA, 32'h3D);
    tx_chk(7'h60, 8'h3D);
    $display("test break done");
    end_of_test();
  end
endmodule : uart_frame_data_control_tb
